// ==== rtl/dpr_top.sv ====
// Discoverable parameter table read path of a serial flash, single-bit SPI.
// Assumes mode 0 on the link (clock idles low), chip select active low,
// a link clock that stops between frames, and a free-running ref_clk_i.
//
// Overview of operation
// (RULE1) Host lowers chip select, sends opcode 5Ah then a 24-bit address.
// (RULE2) Eight dummy clocks follow; data starts on the 40th falling edge.
// (RULE3) Each byte leaves MSB first, output changing on falling edges.
// (RULE4) After each full byte the byte address advances by one.
// (RULE5) Top address is FFh; every byte past it reads FFh.
// (RULE6) A fixed 256-byte read-only table of headers and parameters; only the headers at 00h-1Fh are held, the rest reads FFh.
// (RULE7) Bytes 00h-03h hold signature 53h 46h 44h 50h.
// (RULE8) Byte 04h is minor revision 06h, byte 05h major revision 01h.
// (RULE9) Byte 06h is zero-based header count 02h, three headers.
// (RULE10) First header starts at 08h with identifier 00h.
// (RULE11) Bytes 09h-0Bh: revision 06h, 01h, length 10h double words.
// (RULE12) Bytes 0Ch-0Eh: first pointer 30h, 00h, 00h, low byte first.
// (RULE13) Second header at 10h: maker code, revision 00h 01h, length 04h.
// (RULE14) Bytes 14h-16h: vendor pointer D0h, 00h, 00h, low byte first.
// (RULE15) Third header at 18h holds identifier 84h.
// (RULE16) Bytes 19h-1Bh: revision 00h, 01h, length 02h double words.
// (RULE17) Bytes 1Ch-1Eh: pointer C0h, 00h, 00h, low byte first.
// (RULE18) Reserved bytes 07h, 0Fh, 17h, 1Fh read FFh.
// (RULE19) Chip select high ends the read, releases output, drops address.
`timescale 1ns/1ps
`include "dpr_params.svh"

module dpr_top #(
    // Maker code in the second header; value is arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h5c
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic spi_clk_i,
    input wire logic cs_n_i,
    input wire logic serial_in_line_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic frame_active_o,
    output logic byte_sent_o,
    output logic bad_opcode_o,
    output logic [7:0] byte_count_o
);

    // ------------------------------------------------------------------
    // Link domain: everything below up to the crossing runs on spi_clk_i
    // ------------------------------------------------------------------

    dpr_pkg::dpr_link_st_t state_q;
    dpr_pkg::dpr_link_st_t state_d;
    logic [5:0] clk_cnt_q;
    logic [5:0] clk_cnt_d;
    logic [31:0] in_shift_q;
    logic [31:0] in_word;
    logic [`DPR_ADDR_W-1:0] addr_q;
    logic opcode_ok;

    // Output side state, updated on falling edges
    logic streaming_q;
    logic [2:0] bit_idx_q;
    logic [7:0] ptr_q;
    logic past_top_q;
    logic [7:0] cur_byte_q;
    logic out_q;
    logic oe_q;

    // Event toggles and reset level seen from the link side
    logic byte_tgl_q;
    logic bad_tgl_q;
    logic rst_hold_q;
    logic link_rst_n;
    logic link_rst_n_sync;

    // Table lookup: one fixed byte per address, filler where nothing is defined
    function automatic logic [7:0] table_byte(input logic [7:0] a, input logic [7:0] maker);
        logic [7:0] v;
        v = `DPR_FILL;
        case (a)
            8'h00: v = `DPR_SIG0; // RULE7
            8'h01: v = `DPR_SIG1; // RULE7
            8'h02: v = `DPR_SIG2; // RULE7
            8'h03: v = `DPR_SIG3; // RULE7
            8'h04: v = `DPR_REV_MINOR; // RULE8
            8'h05: v = `DPR_REV_MAJOR; // RULE8
            8'h06: v = `DPR_HDR_COUNT; // RULE9
            8'h07: v = `DPR_FILL; // RULE18
            8'h08: v = `DPR_H0_IDENT; // RULE10
            8'h09: v = `DPR_H0_MINOR; // RULE11
            8'h0a: v = `DPR_H0_MAJOR; // RULE11
            8'h0b: v = `DPR_H0_LEN; // RULE11
            8'h0c: v = `DPR_H0_PTR0; // RULE12
            8'h0d: v = `DPR_H0_PTR1; // RULE12
            8'h0e: v = `DPR_H0_PTR2; // RULE12
            8'h0f: v = `DPR_FILL; // RULE18
            8'h10: v = maker; // RULE13
            8'h11: v = `DPR_H1_MINOR; // RULE13
            8'h12: v = `DPR_H1_MAJOR; // RULE13
            8'h13: v = `DPR_H1_LEN; // RULE13
            8'h14: v = `DPR_H1_PTR0; // RULE14
            8'h15: v = `DPR_H1_PTR1; // RULE14
            8'h16: v = `DPR_H1_PTR2; // RULE14
            8'h17: v = `DPR_FILL; // RULE18
            8'h18: v = `DPR_H2_IDENT; // RULE15
            8'h19: v = `DPR_H2_MINOR; // RULE16
            8'h1a: v = `DPR_H2_MAJOR; // RULE16
            8'h1b: v = `DPR_H2_LEN; // RULE16
            8'h1c: v = `DPR_H2_PTR0; // RULE17
            8'h1d: v = `DPR_H2_PTR1; // RULE17
            8'h1e: v = `DPR_H2_PTR2; // RULE17
            8'h1f: v = `DPR_FILL; // RULE18
            // The pointed-to tables are not held here; they read as filler
            default: v = `DPR_FILL; // RULE6
        endcase
        return v;
    endfunction

    // Incoming word as it will stand after this rising edge
    assign in_word = {in_shift_q[30:0], serial_in_line_i};
    assign opcode_ok = (in_word[7:0] == `DPR_OPCODE);

    // Phase sequencing by count of rising edges since chip select fell
    always_comb begin
        state_d = state_q;
        case (state_q)
            dpr_pkg::DPR_ST_CMD: begin
                if (clk_cnt_q == `DPR_CMD_LAST) begin
                    state_d = opcode_ok ? dpr_pkg::DPR_ST_ADDR : dpr_pkg::DPR_ST_IGNORE; // RULE1
                end
            end
            dpr_pkg::DPR_ST_ADDR: begin
                if (clk_cnt_q == `DPR_ADDR_LAST) begin
                    state_d = dpr_pkg::DPR_ST_DUMMY; // RULE1
                end
            end
            dpr_pkg::DPR_ST_DUMMY: begin
                if (clk_cnt_q == `DPR_DUMMY_LAST) begin
                    state_d = dpr_pkg::DPR_ST_DATA; // RULE2
                end
            end
            dpr_pkg::DPR_ST_DATA: state_d = dpr_pkg::DPR_ST_DATA;
            dpr_pkg::DPR_ST_IGNORE: state_d = dpr_pkg::DPR_ST_IGNORE;
            default: state_d = dpr_pkg::DPR_ST_IGNORE;
        endcase
    end

    // Count saturates once data phase is reached, so it cannot wrap mid-stream
    assign clk_cnt_d = (clk_cnt_q == `DPR_DUMMY_LAST) ? clk_cnt_q : clk_cnt_q + 6'h01;

    // Input side, rising edges; chip select high clears it without a clock
    always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            state_q <= dpr_pkg::DPR_ST_CMD; // RULE19
            clk_cnt_q <= 6'h00;
            in_shift_q <= 32'h0000_0000;
        end else if (!link_rst_n) begin
            state_q <= dpr_pkg::DPR_ST_IGNORE;
            clk_cnt_q <= 6'h00;
            in_shift_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            clk_cnt_q <= clk_cnt_d; // RULE2
            in_shift_q <= in_word; // RULE1
        end
    end

    // Address capture on the last address bit; discarded when the frame ends
    always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            addr_q <= 24'h00_0000; // RULE19
        end else if (state_q == dpr_pkg::DPR_ST_ADDR && clk_cnt_q == `DPR_ADDR_LAST) begin
            addr_q <= in_word[`DPR_ADDR_W-1:0]; // RULE1
        end
    end

    // Output side: next pointer and byte for the stepping logic below
    logic byte_done;
    logic [7:0] ptr_next;
    logic past_next;
    logic [7:0] byte_next;
    logic start_now;
    assign start_now = (state_q == dpr_pkg::DPR_ST_DATA) && !streaming_q;
    assign byte_done = streaming_q && (bit_idx_q == `DPR_BYTE_LAST);
    assign ptr_next = ptr_q + 8'h01; // RULE4
    assign past_next = past_top_q || (ptr_q == `DPR_TOP_ADDR); // RULE5
    assign byte_next = past_next ? `DPR_FILL : table_byte(ptr_next, MAKER_CODE); // RULE5

    // Start byte: an address above the table reads filler from the outset
    logic start_past;
    logic [7:0] start_byte;
    assign start_past = |addr_q[`DPR_ADDR_W-1:8];
    assign start_byte = start_past ? `DPR_FILL : table_byte(addr_q[7:0], MAKER_CODE); // RULE5

    // Falling-edge stepping: each falling edge presents the next bit
    always_ff @(negedge spi_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            streaming_q <= 1'b0; // RULE19
            bit_idx_q <= 3'h7;
            ptr_q <= 8'h00;
            past_top_q <= 1'b0;
            cur_byte_q <= 8'h00;
        end else if (start_now) begin
            streaming_q <= 1'b1; // RULE2
            bit_idx_q <= 3'h7;
            ptr_q <= addr_q[7:0];
            past_top_q <= start_past;
            cur_byte_q <= start_byte;
        end else if (byte_done) begin
            bit_idx_q <= 3'h7;
            ptr_q <= ptr_next; // RULE4
            past_top_q <= past_next; // RULE5
            cur_byte_q <= byte_next;
        end else if (streaming_q) begin
            bit_idx_q <= bit_idx_q - 3'h1;
        end
    end

    // Pin drivers: bit leaves MSB first; released as soon as chip select rises
    always_ff @(negedge spi_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            out_q <= 1'b0;
            oe_q <= 1'b0; // RULE19
        end else if (start_now) begin
            out_q <= start_byte[7]; // RULE3
            oe_q <= 1'b1; // RULE2
        end else if (byte_done) begin
            out_q <= byte_next[7]; // RULE3
            oe_q <= 1'b1;
        end else if (streaming_q) begin
            out_q <= cur_byte_q[bit_idx_q - 3'h1]; // RULE3
            oe_q <= 1'b1;
        end
    end

    assign serial_out_o = out_q;
    assign serial_out_oe_o = oe_q;

    // Event toggles for the reference domain. They are not cleared by chip
    // select, since a clear would look like an event on the far side.
    logic bad_now;
    assign bad_now = (state_q == dpr_pkg::DPR_ST_CMD) && (clk_cnt_q == `DPR_CMD_LAST)
                     && !opcode_ok && !cs_n_i;

    always_ff @(negedge spi_clk_i) begin
        if (!link_rst_n) begin
            byte_tgl_q <= 1'b0;
        end else if (byte_done && !cs_n_i) begin
            byte_tgl_q <= ~byte_tgl_q; // RULE4
        end
    end

    always_ff @(posedge spi_clk_i) begin
        if (!link_rst_n) begin
            bad_tgl_q <= 1'b0;
        end else if (bad_now) begin
            bad_tgl_q <= ~bad_tgl_q;
        end
    end

    // Reset level crossed into the link domain; needs link edges to act
    dpr_sync #(
        .WIDTH(1)
    ) u_rst_to_link (
        .clk_i(spi_clk_i),
        .rst_n_i(1'b1),
        .async_i(rst_hold_q),
        .sync_o(link_rst_n_sync)
    );
    assign link_rst_n = link_rst_n_sync;

    // ------------------------------------------------------------------
    // Reference domain: status seen by the rest of the chip
    // ------------------------------------------------------------------

    logic [2:0] xing_in;
    logic [2:0] xing_out;
    logic cs_active_s;
    logic byte_tgl_s;
    logic bad_tgl_s;
    logic byte_tgl_prev_q;
    logic bad_tgl_prev_q;
    logic active_q;
    logic byte_sent_q;
    logic bad_q;
    logic [7:0] count_q;
    logic [7:0] count_d;

    // Reset to the link is stretched after release: the link only sees it on its
    // own edges, so a short reset would otherwise leave the event toggles unknown.
    // The host must still give a few link clocks, chip select high, meanwhile.
    logic [7:0] rst_cnt_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rst_cnt_q <= 8'h00;
        end else if (rst_cnt_q != `DPR_LINK_RST_HOLD) begin
            rst_cnt_q <= rst_cnt_q + 8'h01;
        end
    end

    // Reset level held in a flop so the link side sees a clean level
    always_ff @(posedge ref_clk_i) begin
        rst_hold_q <= rst_n_i && (rst_cnt_q == `DPR_LINK_RST_HOLD);
    end

    // Chip select level and both toggles pass two flops before use
    assign xing_in = {~cs_n_i, byte_tgl_q, bad_tgl_q};

    dpr_sync #(
        .WIDTH(3)
    ) u_link_to_ref (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(xing_in),
        .sync_o(xing_out)
    );

    assign cs_active_s = xing_out[2];
    assign byte_tgl_s = xing_out[1];
    assign bad_tgl_s = xing_out[0];

    // Count restarts at each new frame; saturates rather than wrapping
    logic frame_start;
    logic byte_evt;
    assign frame_start = cs_active_s && !active_q;
    assign byte_evt = byte_tgl_s ^ byte_tgl_prev_q;
    assign count_d = frame_start ? 8'h00 :
                     (byte_evt && count_q != 8'hff) ? count_q + 8'h01 : count_q;

    // Status flops; every status output comes straight from here
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            byte_tgl_prev_q <= 1'b0;
            bad_tgl_prev_q <= 1'b0;
            active_q <= 1'b0;
            byte_sent_q <= 1'b0;
            bad_q <= 1'b0;
            count_q <= 8'h00;
        end else begin
            byte_tgl_prev_q <= byte_tgl_s;
            bad_tgl_prev_q <= bad_tgl_s;
            active_q <= cs_active_s;
            byte_sent_q <= byte_evt;
            bad_q <= bad_tgl_s ^ bad_tgl_prev_q;
            count_q <= count_d;
        end
    end

    assign frame_active_o = active_q;
    assign byte_sent_o = byte_sent_q;
    assign bad_opcode_o = bad_q;
    assign byte_count_o = count_q;

endmodule

// ==== rtl/dpr_params.svh ====
// Constants for the discoverable parameter read block: opcode, phase ends, table bytes.
// Assumes single-bit SPI, mode 0: input sampled on rising, output on falling edges.
`ifndef DPR_PARAMS_SVH
`define DPR_PARAMS_SVH

// Read instruction code and phase boundaries, counted in rising clock edges
`define DPR_OPCODE 8'h5a
`define DPR_CMD_LAST 6'h07
`define DPR_ADDR_LAST 6'h1f
`define DPR_DUMMY_LAST 6'h27
`define DPR_ADDR_W 24
`define DPR_BYTE_LAST 3'h0
`define DPR_TOP_ADDR 8'hff

// Reference cycles that the link reset is held after release
`define DPR_LINK_RST_HOLD 8'h40

// Filler for reserved bytes, uncovered bytes and reads past the top
`define DPR_FILL 8'hff

// Table header: signature, format revision, header count
`define DPR_SIG0 8'h53
`define DPR_SIG1 8'h46
`define DPR_SIG2 8'h44
`define DPR_SIG3 8'h50
`define DPR_REV_MINOR 8'h06
`define DPR_REV_MAJOR 8'h01
`define DPR_HDR_COUNT 8'h02

// First header: basic flash parameters
`define DPR_H0_IDENT 8'h00
`define DPR_H0_MINOR 8'h06
`define DPR_H0_MAJOR 8'h01
`define DPR_H0_LEN 8'h10
`define DPR_H0_PTR0 8'h30
`define DPR_H0_PTR1 8'h00
`define DPR_H0_PTR2 8'h00

// Second header: maker table
`define DPR_H1_MINOR 8'h00
`define DPR_H1_MAJOR 8'h01
`define DPR_H1_LEN 8'h04
`define DPR_H1_PTR0 8'hd0
`define DPR_H1_PTR1 8'h00
`define DPR_H1_PTR2 8'h00

// Third header: four-byte-address instruction table
`define DPR_H2_IDENT 8'h84
`define DPR_H2_MINOR 8'h00
`define DPR_H2_MAJOR 8'h01
`define DPR_H2_LEN 8'h02
`define DPR_H2_PTR0 8'hc0
`define DPR_H2_PTR1 8'h00
`define DPR_H2_PTR2 8'h00

`endif

// ==== rtl/dpr_pkg.sv ====
// Types shared by the discoverable parameter read block.
// Assumes nothing of its surroundings.
package dpr_pkg;

    // Phase of a transaction on the serial link, one-hot
    typedef enum logic [4:0] {
        DPR_ST_CMD    = 5'b00001,
        DPR_ST_ADDR   = 5'b00010,
        DPR_ST_DUMMY  = 5'b00100,
        DPR_ST_DATA   = 5'b01000,
        DPR_ST_IGNORE = 5'b10000
    } dpr_link_st_t;

endpackage

// ==== rtl/dpr_sync.sv ====
// Two-flop level synchroniser, one per bit.
// Assumes each input bit is a level or a toggle that holds for two destination edges.
`timescale 1ns/1ps
module dpr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    meta_q[b] <= 1'b0;
                    sync_q[b] <= 1'b0;
                end else begin
                    meta_q[b] <= async_i[b];
                    sync_q[b] <= meta_q[b];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;

endmodule

// ==== verification/dpr_top_sva.sv ====
// Checker for the parameter read block, watching only its top-level ports.
// Assumes mode 0 on the link and a host that keeps chip select high between frames.
`timescale 1ns/1ps
module dpr_top_sva (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic spi_clk_i,
    input wire logic cs_n_i,
    input wire logic serial_in_line_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    input wire logic frame_active_o,
    input wire logic byte_sent_o,
    input wire logic bad_opcode_o,
    input wire logic [7:0] byte_count_o
);
    logic [5:0] rise_cnt_q;
    logic [7:0] op_q;

    // Rising edges and opcode of the current frame; chip select high clears them, as in the link
    always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rise_cnt_q <= 6'h00;
            op_q <= 8'h00;
        end else begin
            rise_cnt_q <= (rise_cnt_q == 6'h3f) ? rise_cnt_q : rise_cnt_q + 6'h01;
            op_q <= (rise_cnt_q < 6'h08) ? {op_q[6:0], serial_in_line_i} : op_q;
        end
    end

    a_no_early_drive: assert property (@(posedge spi_clk_i) disable iff (cs_n_i || !rst_n_i)
        rise_cnt_q < 6'h28 |-> !serial_out_oe_o) else $error("output driven before dummy end");
    a_data_on_time: assert property (@(posedge spi_clk_i) disable iff (cs_n_i || !rst_n_i)
        rise_cnt_q >= 6'h28 && op_q == 8'h5a |-> serial_out_oe_o)
        else $error("output not driven in data phase");
    a_bad_op_silent: assert property (@(posedge spi_clk_i) disable iff (cs_n_i || !rst_n_i)
        rise_cnt_q > 6'h08 && op_q != 8'h5a |-> !serial_out_oe_o)
        else $error("output driven after wrong opcode");
    a_release_on_cs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cs_n_i |-> !serial_out_oe_o && !serial_out_o) else $error("output held after deselect");
    a_change_at_fall: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !cs_n_i && $changed(serial_out_o) |-> !spi_clk_i) else $error("data changed off falling edge");
    a_sent_single: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        byte_sent_o |=> !byte_sent_o) else $error("byte pulse longer than one cycle");
    a_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $changed(byte_count_o) |-> byte_count_o == $past(byte_count_o) + 8'h01
        || byte_count_o == 8'h00) else $error("byte count jumped");
    a_bad_single: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bad_opcode_o |=> !bad_opcode_o) else $error("bad opcode pulse too long");
    a_active_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(cs_n_i) |-> ##[1:4] frame_active_o) else $error("frame start not seen");
    a_active_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(cs_n_i) |-> ##[1:4] !frame_active_o) else $error("frame end not seen");
endmodule

bind dpr_top dpr_top_sva i_dpr_top_sva (.ref_clk_i, .rst_n_i, .spi_clk_i, .cs_n_i,
    .serial_in_line_i, .serial_out_o, .serial_out_oe_o, .frame_active_o, .byte_sent_o,
    .bad_opcode_o, .byte_count_o);

// ==== verification/dpr_host_model.sv ====
// Behavioural SPI host, mode 0, that runs parameter read frames on demand.
// Assumes the bench calls its tasks one at a time; the link clock stops between frames.
`timescale 1ns/1ps
module dpr_host_model (
    output logic spi_clk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic oe_i
);
    logic [7:0] got [0:39];
    int oe_seen;

    // Idle levels: deselected, clock low; a clean rise of chip select clears the link pins
    initial begin
        spi_clk_o = 1'b0;
        cs_n_o = 1'b0;
        mosi_o = 1'b0;
        oe_seen = 0;
        #1 cs_n_o = 1'b1;
    end

    // Clocks with chip select high, so the link side sees reset release
    task automatic idle(input int n);
        repeat (n) begin
            #32 spi_clk_o = 1'b1;
            #32 spi_clk_o = 1'b0;
        end
    endtask

    // One frame; a nonzero cut stops after that many rising edges
    task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int nbytes,
                         input int cut);
        logic [31:0] sh;
        int n;
        sh = {op, adr};
        n = (cut != 0) ? cut : 40 + 8 * nbytes;
        oe_seen = 0;
        cs_n_o = 1'b0;
        for (int k = 0; k < n; k++) begin
            // Input released after the address: toggle so nothing reads as a held value
            mosi_o = (k < 32) ? sh[31-k] : ~mosi_o;
            #32 spi_clk_o = 1'b1;
            if (k >= 40) got[(k-40)/8][7-(k-40)%8] = miso_i;
            if (oe_i === 1'b1) oe_seen++;
            #32 spi_clk_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #64;
    endtask
endmodule

// ==== verification/dpr_top_test.sv ====
// Self-checking bench: the host model reads the parameter table in several ways.
// Assumes the design and its checker are compiled beforehand.
`timescale 1ns/1ps
module dpr_top_test;
    localparam logic [7:0] MAKER = 8'h3b; // Maker code value is arbitrary
    localparam logic [7:0] TBL [0:31] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02,
        8'hff, 8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff, MAKER, 8'h00, 8'h01,
        8'h04, 8'hd0, 8'h00, 8'h00, 8'hff, 8'h84, 8'h00, 8'h01, 8'h02, 8'hc0, 8'h00, 8'h00,
        8'hff};
    logic ref_clk_i, rst_n_i, spi_clk, cs_n, mosi, miso, oe, sent, bad, act;
    logic [7:0] count;
    int mismatches = 0, n_tests = 0, cycles = 0, n_sent = 0, n_bad = 0;

    dpr_top #(.MAKER_CODE(MAKER)) i_dpr_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .spi_clk_i(spi_clk), .cs_n_i(cs_n), .serial_in_line_i(mosi), .serial_out_o(miso),
        .serial_out_oe_o(oe), .frame_active_o(act), .byte_sent_o(sent), .bad_opcode_o(bad),
        .byte_count_o(count));
    dpr_host_model i_dpr_host_model (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso), .oe_i(oe));

    // Reference clock
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // Pulse counters and the hang limit, about four times the expected run;
    // sampled on the falling edge, away from the edge that launches the pulses
    always @(negedge ref_clk_i) begin
        cycles++;
        if (sent === 1'b1) n_sent++;
        if (bad === 1'b1) n_bad++;
        if (cycles == 30000) begin
            mismatches++;
            $display("ERROR %0t run did not finish", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_byte(input int a);
        return (a < 32) ? TBL[a] : 8'hff;
    endfunction

    function automatic logic [7:0] rd(input int i);
        return i_dpr_host_model.got[i];
    endfunction

    // Let the status crossing land
    task automatic settle();
        repeat (8) @(negedge ref_clk_i);
    endtask

    // Headers and the first filler bytes streamed in one frame
    task automatic t_table();
        n_sent = 0;
        fork
            i_dpr_host_model.frame(8'h5a, 24'h000000, 34, 0);
            begin
                repeat (20) @(negedge ref_clk_i);
                chk(8'(act), 8'h01, "frame active");
            end
        join
        settle();
        chk(8'(act), 8'h00, "frame end");
        for (int i = 0; i < 12; i++) chk(rd(i), exp_byte(i), "tbl");
        for (int i = 12; i < 24; i++) chk(rd(i), exp_byte(i), "tbl");
        for (int i = 24; i < 34; i++) chk(rd(i), exp_byte(i), "tbl");
        chk(count, 8'h22, "byte count");
        chk(8'(n_sent), 8'h22, "byte pulses");
    endtask

    // Starts near the end of the headers, just below the top, and above the table
    task automatic t_past_top();
        logic [23:0] starts [0:2];
        starts = '{24'h00001e, 24'h0000fe, 24'h010000};
        foreach (starts[s]) begin
            i_dpr_host_model.frame(8'h5a, starts[s], 4, 0);
            settle();
            for (int i = 0; i < 4; i++) chk(rd(i), exp_byte(int'(starts[s]) + i), "top");
        end
    endtask

    // Other opcodes get no answer and one flag pulse each
    task automatic t_bad_opcode();
        logic [7:0] ops [0:2];
        ops = '{8'h03, 8'h5b, 8'ha5};
        foreach (ops[o]) begin
            n_bad = 0;
            i_dpr_host_model.frame(ops[o], 24'h000000, 2, 0);
            settle();
            chk(8'(i_dpr_host_model.oe_seen), 8'h00, "drive on bad op");
            chk(8'(n_bad), 8'h01, "bad op flag");
        end
    endtask

    // Frames cut in the address and in a data byte, then a fresh read
    task automatic t_abort();
        i_dpr_host_model.frame(8'h5a, 24'h000000, 3, 20);
        chk(8'(i_dpr_host_model.oe_seen), 8'h00, "drive after cut");
        i_dpr_host_model.frame(8'h5a, 24'h000010, 2, 44);
        i_dpr_host_model.frame(8'h5a, 24'h000004, 3, 0);
        settle();
        for (int i = 0; i < 3; i++) chk(rd(i), exp_byte(4 + i), "after cut");
        chk(count, 8'h03, "count after cut");
    endtask

    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        // Link clocks with chip select high while the stretched link reset passes
        i_dpr_host_model.idle(12);
        t_table();
        t_past_top();
        t_bad_opcode();
        t_abort();
        tally_and_finish();
    end
endmodule
